/* rtl/fpm_pkg.sv */
// shared constants and types for the front panel menu controller
package fpm_pkg;

  // ----------------------------------------------------------------
  // clock and tick
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 200;
  localparam int TICK_US  = 1000;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;

  // ----------------------------------------------------------------
  // button timing, in ms ticks
  // ----------------------------------------------------------------
  localparam logic [4:0]  DEB_MS        = 5'h14;
  localparam logic [11:0] LONG_MS       = 12'h3e8;
  localparam logic [11:0] BACK_MIN_MS   = 12'h12c;
  localparam logic [11:0] DARK_PAUSE_MS = 12'h7d0;
  localparam logic [18:0] IDLE_MS       = 19'h493e0;

  // ----------------------------------------------------------------
  // display self-test
  // ----------------------------------------------------------------
  localparam int          TEST_TOTAL_MS = 15000;
  localparam logic [4:0]  PASS_STEPS    = 5'h0b;
  localparam logic [4:0]  TEST_STEPS    = 5'h16;
  localparam logic [9:0]  TEST_STEP_MS  =
    10'(TEST_TOTAL_MS / int'(TEST_STEPS));
  localparam logic [4:0]  OUTER_STEPS   = 5'h06;
  localparam logic [4:0]  DP_STEP       = 5'h06;

  // ----------------------------------------------------------------
  // menu sizes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MAIN_LAST = 3'h7;
  localparam logic [1:0] SUB_LAST  = 2'h3;
  localparam logic [2:0] POS_DARK  = 3'h0;
  localparam logic [1:0] SUB_NONE  = 2'h0;

  // ----------------------------------------------------------------
  // panel states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FPM_TEST = 3'h0,
    FPM_DARK = 3'h1,
    FPM_MAIN = 3'h3,
    FPM_SUB  = 3'h2,
    FPM_SET  = 3'h6
  } fpm_state_t;

endpackage : fpm_pkg

/* rtl/fpm_panel.sv */
// front panel controller: display, self-test and two-button menu
`timescale 1ns/1ps

module fpm_panel #(
  parameter int TICK_CYC = fpm_pkg::TICK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        step_btn,
  input  wire logic        prog_btn,
  input  wire logic [11:0] item_value,
  input  wire logic [7:0]  item_lamp,
  input  wire logic        item_is_rec,
  input  wire logic [3:0]  item_rec_no,
  input  wire logic        op_ind_valid,
  input  wire logic [3:0]  op_ind_code,
  output logic      [7:0]  red_seg,
  output logic      [23:0] grn_seg,
  output logic      [7:0]  lamp,
  output logic      [2:0]  menu_pos,
  output logic      [1:0]  sub_pos,
  output logic             ind_clr,
  output logic             set_commit,
  output logic             set_mode,
  output logic             test_active
);

  typedef struct packed {
    logic [1:0]       s1;
    logic [1:0]       s2;
    logic [1:0]       s3;
    logic [1:0]       deb;
    logic [1:0][4:0]  dbc;
    logic [17:0]      div;
    fpm_pkg::fpm_state_t st;
    logic [4:0]       tstep;
    logic [9:0]       tms;
    logic [11:0]      shold;
    logic [11:0]      slim;
    logic             sfired;
    logic [11:0]      phold;
    logic             plong;
    logic [18:0]      idle;
    logic [2:0]       mpos;
    logic [1:0]       spos;
    logic [7:0]       red;
    logic [23:0]      grn;
    logic [7:0]       lamp;
    logic             clr;
    logic             commit;
  } fpm_regs_t;

  fpm_regs_t q;
  fpm_regs_t d;
  logic      rst_meta_q;
  logic      rst_n_q;
  logic      tick;
  logic      srise;
  logic      sfall;
  logic      prise;
  logic      pfall;
  logic      fwd;
  logic      back;
  logic      prel;
  logic      flash;
  logic      tout;
  logic [4:0] tsel;
  logic [7:0] tpat;

  function automatic logic [7:0] fpm_seg(input logic [3:0] v);
    case (v)
      4'h0:    fpm_seg = 8'h3f;
      4'h1:    fpm_seg = 8'h06;
      4'h2:    fpm_seg = 8'h5b;
      4'h3:    fpm_seg = 8'h4f;
      4'h4:    fpm_seg = 8'h66;
      4'h5:    fpm_seg = 8'h6d;
      4'h6:    fpm_seg = 8'h7d;
      4'h7:    fpm_seg = 8'h07;
      4'h8:    fpm_seg = 8'h7f;
      4'h9:    fpm_seg = 8'h6f;
      4'ha:    fpm_seg = 8'h77;
      4'hb:    fpm_seg = 8'h7c;
      4'hc:    fpm_seg = 8'h39;
      4'hd:    fpm_seg = 8'h5e;
      4'he:    fpm_seg = 8'h79;
      default: fpm_seg = 8'h71;
    endcase
  endfunction : fpm_seg

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    d.clr    = 1'b0;
    d.commit = 1'b0;
    fwd      = 1'b0;
    back     = 1'b0;
    prel     = 1'b0;
    // bit 0 is step, bit 1 is program
    d.s1 = {prog_btn, step_btn};
    d.s2 = q.s1;
    d.s3 = q.s2;
    tick = (q.div == 18'(TICK_CYC - 1));
    d.div = tick ? 18'h00000 : q.div + 18'h00001;
    for (int i = 0; i < 2; i++)
    begin
      if (q.s2[i] == q.s3[i] && q.s3[i] != q.deb[i])
      begin
        // count ticks, so the level holds at least DEB_MS - 1 whole ticks before it is taken
        if (tick)
        begin
          d.dbc[i] = q.dbc[i] + 5'h01;
          if (q.dbc[i] == fpm_pkg::DEB_MS - 5'h01)
          begin
            d.deb[i] = q.s3[i];
            d.dbc[i] = 5'h00;
          end
        end
      end
      else
        d.dbc[i] = 5'h00;
    end
    srise = d.deb[0] & ~q.deb[0];
    sfall = ~d.deb[0] & q.deb[0];
    prise = d.deb[1] & ~q.deb[1];
    pfall = ~d.deb[1] & q.deb[1];

    // idle time since last step press
    if (tick && q.idle != fpm_pkg::IDLE_MS)
      d.idle = q.idle + 19'h00001;
    tout = (q.idle == fpm_pkg::IDLE_MS);

    // step press timing, forward on hold, back on short release
    if (srise)
    begin
      // each step press clears latched indicators
      d.clr    = 1'b1;
      d.idle   = 19'h00000;
      d.shold  = 12'h000;
      d.slim   = fpm_pkg::LONG_MS;
      d.sfired = 1'b0;
    end
    else if (q.deb[0] && tick)
    begin
      if (q.shold + 12'h001 >= q.slim)
      begin
        fwd      = 1'b1;
        d.shold  = 12'h000;
        d.slim   = fpm_pkg::LONG_MS;
        d.sfired = 1'b1;
      end
      else
        d.shold = q.shold + 12'h001;
    end
    if (sfall && !q.sfired && q.shold >= fpm_pkg::BACK_MIN_MS)
      back = 1'b1;

    if (prise)
    begin
      d.phold = 12'h000;
      d.plong = 1'b0;
    end
    else if (q.deb[1] && tick && !q.plong)
    begin
      d.phold = q.phold + 12'h001;
      if (q.phold + 12'h001 >= fpm_pkg::LONG_MS)
        d.plong = 1'b1;
    end
    if (pfall)
    begin
      // a long press that matures on the release cycle still counts
      prel    = d.plong;
      d.plong = 1'b0;
    end

    // ----------------------------------------------------------------
    // menu walk
    // ----------------------------------------------------------------
    case (q.st)
      fpm_pkg::FPM_TEST:
      begin
        if (tick)
        begin
          d.tms = q.tms + 10'h001;
          if (q.tms == fpm_pkg::TEST_STEP_MS - 10'h001)
          begin
            d.tms = 10'h000;
            if (q.tstep == fpm_pkg::TEST_STEPS - 5'h01)
              d.st = fpm_pkg::FPM_DARK;
            else
              d.tstep = q.tstep + 5'h01;
          end
        end
        if (srise)
          d.st = fpm_pkg::FPM_DARK;
      end
      fpm_pkg::FPM_DARK:
      begin
        if (fwd)
        begin
          d.st   = fpm_pkg::FPM_MAIN;
          d.mpos = 3'h1;
        end
      end
      fpm_pkg::FPM_MAIN:
      begin
        if (tout)
        begin
          d.st   = fpm_pkg::FPM_DARK;
          d.mpos = fpm_pkg::POS_DARK;
        end
        else if (fwd)
        begin
          if (q.mpos == fpm_pkg::MAIN_LAST)
          begin
            d.st   = fpm_pkg::FPM_DARK;
            d.mpos = fpm_pkg::POS_DARK;
            d.slim = fpm_pkg::LONG_MS + fpm_pkg::DARK_PAUSE_MS;
          end
          else
            d.mpos = q.mpos + 3'h1;
        end
        else if (back)
        begin
          d.mpos = q.mpos - 3'h1;
          if (q.mpos == 3'h1)
            d.st = fpm_pkg::FPM_DARK;
        end
        // long program press enters submenu on release
        else if (prel)
        begin
          d.st   = fpm_pkg::FPM_SUB;
          d.spos = 2'h1;
        end
      end
      fpm_pkg::FPM_SUB:
      begin
        if (tout)
        begin
          d.st   = fpm_pkg::FPM_DARK;
          d.mpos = fpm_pkg::POS_DARK;
          d.spos = fpm_pkg::SUB_NONE;
        end
        // same stepping, wrap back to main menu
        else if (fwd)
        begin
          d.spos = q.spos + 2'h1;
          if (q.spos == fpm_pkg::SUB_LAST)
            d.st = fpm_pkg::FPM_MAIN;
        end
        else if (back)
        begin
          d.spos = q.spos - 2'h1;
          if (q.spos == 2'h1)
            d.st = fpm_pkg::FPM_MAIN;
        end
        else if (prel)
          d.st = fpm_pkg::FPM_SET;
      end
      fpm_pkg::FPM_SET:
      begin
        // stepping edits digits here, so menu moves are ignored
        if (tout)
        begin
          d.st   = fpm_pkg::FPM_DARK;
          d.mpos = fpm_pkg::POS_DARK;
          d.spos = fpm_pkg::SUB_NONE;
        end
        // step with program held, or both pressed together, commits
        // buttons pressed together debounce on the same cycle
        else if (srise && (q.deb[1] || prise))
        begin
          d.commit = 1'b1;
          d.sfired = 1'b1;
          d.st     = fpm_pkg::FPM_SUB;
        end
        else if (prel)
          d.st = fpm_pkg::FPM_SUB;
      end
      default:
        d.st = fpm_pkg::FPM_DARK;
    endcase

    // ----------------------------------------------------------------
    // display image
    // ----------------------------------------------------------------
    flash = q.idle[8];
    tsel  = (q.tstep >= fpm_pkg::PASS_STEPS)
            ? q.tstep - fpm_pkg::PASS_STEPS : q.tstep;
    // outer segments clockwise, then decimal points
    if (tsel < fpm_pkg::OUTER_STEPS)
      tpat = 8'h01 << tsel[2:0];
    else if (tsel == fpm_pkg::DP_STEP)
      tpat = 8'h80;
    else
      tpat = 8'h00;
    d.red  = 8'h00;
    d.grn  = 24'h000000;
    d.lamp = 8'h00;
    case (q.st)
      fpm_pkg::FPM_TEST:
      begin
        // all digits share the outer pattern
        d.red = tpat;
        d.grn = {tpat, tpat, tpat};
        // middle segment, red digit first then greens
        if (tsel == fpm_pkg::DP_STEP + 5'h01)
          d.red = 8'h40;
        if (tsel == fpm_pkg::DP_STEP + 5'h02)
          d.grn = 24'h400000;
        if (tsel == fpm_pkg::DP_STEP + 5'h03)
          d.grn = 24'h004000;
        if (tsel == fpm_pkg::DP_STEP + 5'h04)
          d.grn = 24'h000040;
      end
      fpm_pkg::FPM_DARK:
      begin
        if (op_ind_valid)
          d.red = fpm_seg(op_ind_code);
      end
      fpm_pkg::FPM_MAIN:
      begin
        // code in red, value in green
        d.red  = fpm_seg(item_is_rec ? item_rec_no : {1'b0, q.mpos});
        d.grn  = {fpm_seg(item_value[11:8]), fpm_seg(item_value[7:4]),
                  fpm_seg(item_value[3:0])};
        d.lamp = item_lamp;
      end
      default:
      begin
        // flashing red address in submenu and setting mode
        d.red  = flash ? 8'h00 : fpm_seg({2'b00, q.spos});
        d.grn  = {fpm_seg(item_value[11:8]), fpm_seg(item_value[7:4]),
                  fpm_seg(item_value[3:0])};
        if (q.st == fpm_pkg::FPM_SET && flash)
          d.grn = 24'h000000;
        // the item lamp stays lit in submenu and setting mode
        d.lamp = item_lamp;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      q       <= '0;
      q.st    <= fpm_pkg::FPM_TEST;
      q.slim  <= fpm_pkg::LONG_MS;
      q.mpos  <= fpm_pkg::POS_DARK;
      q.spos  <= fpm_pkg::SUB_NONE;
    end
    else
      q <= d;
  end

  // no protection path passes through this block, so the
  // self-test cannot hold any of it off
  assign red_seg     = q.red;
  assign grn_seg     = q.grn;
  assign lamp        = q.lamp;
  assign menu_pos    = q.mpos;
  assign sub_pos     = q.spos;
  assign ind_clr     = q.clr;
  assign set_commit  = q.commit;
  assign set_mode    = (q.st == fpm_pkg::FPM_SET);
  assign test_active = (q.st == fpm_pkg::FPM_TEST);

endmodule : fpm_panel

/* testbench/fpm_properties.sv */
// concurrent checks on the front panel controller ports
`timescale 1ns/1ps

module fpm_properties (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [7:0]  red_seg,
  input wire logic [23:0] grn_seg,
  input wire logic [7:0]  lamp,
  input wire logic [2:0]  menu_pos,
  input wire logic [1:0]  sub_pos,
  input wire logic        ind_clr,
  input wire logic        set_commit,
  input wire logic        set_mode,
  input wire logic        test_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // assertions and cover points
  // ----------------------------------------------------------------
  clr_pulse_a: assert property (ind_clr |=> !ind_clr)
    else $error("ind_clr longer than one cycle");
  commit_mode_a: assert property (set_commit |-> $past(set_mode))
    else $error("commit outside setting mode");
  commit_pulse_a: assert property (set_commit |=> !set_commit)
    else $error("set_commit longer than one cycle");
  outer_match_a: assert property (
    test_active && red_seg != 8'h00 && !red_seg[6]
    |-> grn_seg == {3{red_seg}}) else $error("outer segments differ");
  middle_one_a: assert property (
    test_active && (red_seg[6] || grn_seg[22] || grn_seg[14] || grn_seg[6])
    |-> $onehot({red_seg, grn_seg})) else $error("middle not one digit");
  dark_fwd_a: assert property (
    $past(menu_pos) == 3'h0 && menu_pos != 3'h0 |-> menu_pos == 3'h1)
    else $error("left dark backwards");
  abort_test_a: assert property (
    ind_clr && test_active |-> ##[0:2] !test_active)
    else $error("self-test not aborted");
  dark_green_a: assert property (
    !test_active && !$past(test_active) && menu_pos == 3'h0
    && $past(menu_pos) == 3'h0 |-> grn_seg == 24'h0 && lamp == 8'h00)
    else $error("green lit while dark");
  sub_main_a: assert property (sub_pos != 2'h0 |-> menu_pos != 3'h0)
    else $error("submenu without main position");
  test_quiet_a: assert property (
    test_active |-> menu_pos == 3'h0 && !set_mode && !set_commit)
    else $error("menu active during self-test");

  c_commit: cover property (set_commit);
  c_sub: cover property ($rose(sub_pos != 2'h0));
  c_test_end: cover property ($fell(test_active));
endmodule : fpm_properties

bind fpm_panel fpm_properties fpm_properties_i (
  .sys_clk(sys_clk), .rstn(rstn), .red_seg(red_seg), .grn_seg(grn_seg),
  .lamp(lamp), .menu_pos(menu_pos), .sub_pos(sub_pos), .ind_clr(ind_clr),
  .set_commit(set_commit), .set_mode(set_mode),
  .test_active(test_active));

/* testbench/fpm_operator.sv */
// operator model pressing the two front panel buttons
`timescale 1ns/1ps

module fpm_operator (
  input  wire logic sys_clk,
  output logic      step_btn,
  output logic      prog_btn
);
  initial
  begin
    step_btn = 1'b0;
    prog_btn = 1'b0;
  end

  task automatic bounce(input logic s, input logic p);
    repeat (3)
    begin
      @(negedge sys_clk);
      step_btn = s;
      prog_btn = p;
      @(negedge sys_clk);
      step_btn = 1'b0;
      prog_btn = 1'b0;
    end
    @(negedge sys_clk);
    step_btn = s;
    prog_btn = p;
  endtask : bounce

  // hold length set by caller, buttons together
  task automatic hold(input logic s, input logic p);
    bounce(s, p);
  endtask : hold

  task automatic release_all();
    bounce(1'b0, 1'b0);
  endtask : release_all
endmodule : fpm_operator

/* testbench/test_front_panel_menu_controller.sv */
// self-checking testbench for the front panel controller
`timescale 1ns/1ps

module test_front_panel_menu_controller;
  localparam int TK = 2;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        step_btn;
  logic        prog_btn;
  logic [11:0] item_value   = 12'h123;
  logic [7:0]  item_lamp    = 8'h04;
  logic        item_is_rec  = 1'b0;
  logic [3:0]  item_rec_no  = 4'h5;
  logic        op_ind_valid = 1'b0;
  logic [3:0]  op_ind_code  = 4'h2;
  logic [7:0]  red_seg;
  logic [23:0] grn_seg;
  logic [7:0]  lamp;
  logic [2:0]  menu_pos;
  logic [1:0]  sub_pos;
  logic        ind_clr;
  logic        set_commit;
  logic        set_mode;
  logic        test_active;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          clr_n      = 0;
  int          com_n      = 0;

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (ind_clr === 1'b1) clr_n <= clr_n + 1;
    if (set_commit === 1'b1) com_n <= com_n + 1;
  end

  fpm_operator fpm_operator_i (.sys_clk(sys_clk), .step_btn(step_btn),
    .prog_btn(prog_btn));

  fpm_panel #(.TICK_CYC(TK)) fpm_panel_i (
    .sys_clk(sys_clk), .rstn(rstn), .step_btn(step_btn),
    .prog_btn(prog_btn), .item_value(item_value), .item_lamp(item_lamp),
    .item_is_rec(item_is_rec), .item_rec_no(item_rec_no),
    .op_ind_valid(op_ind_valid), .op_ind_code(op_ind_code),
    .red_seg(red_seg), .grn_seg(grn_seg), .lamp(lamp),
    .menu_pos(menu_pos), .sub_pos(sub_pos), .ind_clr(ind_clr),
    .set_commit(set_commit), .set_mode(set_mode),
    .test_active(test_active));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wt(input int ticks);
    repeat (ticks * TK) @(negedge sys_clk);
  endtask : wt

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic press(input logic s, input logic p, input int ticks);
    fpm_operator_i.hold(s, p);
    wt(ticks);
    fpm_operator_i.release_all();
    wt(100);
  endtask : press

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_selftest();
    int          n;
    logic [7:0]  rs;
    logic [23:0] gs;
    n = 0;
    rs = 8'h00;
    gs = 24'h0;
    chk(24'(test_active), 24'h1);
    chk(grn_seg, 24'h0);
    rstn = 1'b1;
    while (test_active === 1'b1 && n < 40000)
    begin
      @(negedge sys_clk);
      rs = rs | red_seg;
      gs = gs | grn_seg;
      n++;
    end
    chk(24'(n > 29864 && n < 30064), 24'h1);
    chk(24'(rs), 24'hff);
    chk(gs, 24'hffffff);
    wt(2);
    chk({red_seg, grn_seg[15:0]}, 24'h0);
    chk(grn_seg, 24'h0);
    $display("test selftest done");
  endtask : t_selftest

  task automatic t_dark_ind();
    op_ind_valid = 1'b1;
    wt(5);
    chk(grn_seg, 24'h0);
    chk(24'(red_seg), 24'h5b);
    op_ind_valid = 1'b0;
    $display("test dark indicator done");
  endtask : t_dark_ind

  task automatic t_back_dark();
    int c0;
    c0 = clr_n;
    press(1'b1, 1'b0, 500);
    chk(24'(menu_pos), 24'h0);
    chk(24'(clr_n - c0), 24'h1);
    $display("test back from dark done");
  endtask : t_back_dark

  task automatic t_repeat();
    fpm_operator_i.hold(1'b1, 1'b0);
    wt(3500);
    chk(24'(menu_pos), 24'h3);
    wt(4900);
    chk(24'(menu_pos), 24'h0);
    wt(2000);
    chk(24'(menu_pos), 24'h0);
    fpm_operator_i.release_all();
    wt(100);
    chk(24'(menu_pos), 24'h0);
    $display("test held step done");
  endtask : t_repeat

  task automatic t_fwd_back();
    press(1'b1, 1'b0, 1200);
    chk(24'(menu_pos), 24'h1);
    chk(24'(lamp), 24'(item_lamp));
    chk(24'(red_seg), 24'h06);
    chk(grn_seg, 24'h065b4f);
    item_is_rec = 1'b1;
    wt(1);
    chk(24'(red_seg), 24'h6d);
    item_is_rec = 1'b0;
    press(1'b1, 1'b0, 1200);
    chk(24'(menu_pos), 24'h2);
    press(1'b1, 1'b0, 500);
    chk(24'(menu_pos), 24'h1);
    $display("test forward back done");
  endtask : t_fwd_back

  task automatic t_sub();
    logic [1:0] seen;
    seen = 2'b00;
    press(1'b0, 1'b1, 1200);
    chk(24'(sub_pos), 24'h1);
    chk(24'(lamp), 24'(item_lamp));
    repeat (1100 * TK)
    begin
      @(negedge sys_clk);
      seen = seen | {red_seg != 8'h00, red_seg == 8'h00};
    end
    chk(24'(seen), 24'h3);
    press(1'b1, 1'b0, 1200);
    chk(24'(sub_pos), 24'h2);
    press(1'b1, 1'b0, 500);
    chk(24'(sub_pos), 24'h1);
    repeat (3) press(1'b1, 1'b0, 1200);
    chk(24'({sub_pos, menu_pos}), 24'h1);
    $display("test submenu done");
  endtask : t_sub

  task automatic t_set();
    int c0;
    press(1'b0, 1'b1, 1200);
    press(1'b0, 1'b1, 1200);
    chk(24'(set_mode), 24'h1);
    c0 = com_n;
    press(1'b1, 1'b1, 100);
    chk(24'(com_n - c0), 24'h1);
    chk(24'(set_mode), 24'h0);
    chk(24'(sub_pos), 24'h1);
    $display("test setting commit done");
  endtask : t_set

  task automatic t_abort();
    rstn = 1'b0;
    wt(5);
    rstn = 1'b1;
    wt(1000);
    chk(24'(test_active), 24'h1);
    press(1'b1, 1'b0, 100);
    chk(24'(test_active), 24'h0);
    chk(24'(menu_pos), 24'h0);
    $display("test abort done");
  endtask : t_abort

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge sys_clk);
    t_selftest();
    t_dark_ind();
    t_back_dark();
    t_repeat();
    t_fwd_back();
    t_sub();
    t_set();
    t_abort();
    complete_run();
  end

  // the scenarios take about 83200 cycles; the limit leaves some margin
  initial
  begin
    repeat (95000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
endmodule : test_front_panel_menu_controller
